/* design/flash_seq_regs.svh */
// Constants for the flash erase and suspend sequencer host controller.
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

`define CLK_MHZ          40
`define ERASE_WINDOW_US  50
`define SUSPEND_LAT_US   20
`define PROT_ABORT_US    100
`define ERS_RESUME_US    400
`define PGM_RESUME_US    5
`define SETUP_CYCLES     6
`define US_TO_CYC(us)    ((us) * `CLK_MHZ)

// Status byte field positions.
`define ST_POLL          7
`define ST_TOGGLE        6
`define ST_TLIMIT        5
`define ST_ETIMER        3
`define ST_STOGGLE       2
`define ST_BABORT        1

// Default command table, all of it replaceable by parameters.
`define UNLOCK1_ADDR     24'h000555
`define UNLOCK1_DATA     16'h00AA
`define UNLOCK2_ADDR     24'h0002AA
`define UNLOCK2_DATA     16'h0055
`define CONFIG_DATA      16'h0080
`define SECT_ERASE_DATA  16'h0030
`define CHIP_ERASE_DATA  16'h0010
`define SUSPEND_DATA     16'h00B0
`define RESUME_DATA      16'h0030
`define RESET_DATA       16'h00F0

`endif

/* design/flash_seq_pkg.sv */
// Types shared by the flash sequencer host controller.
package flash_seq_pkg;

  typedef enum logic [2:0] {
    OP_SECT_ERASE,
    OP_ADD_SECTOR,
    OP_CHIP_ERASE,
    OP_ERASE_SUSPEND,
    OP_ERASE_RESUME,
    OP_PGM_SUSPEND,
    OP_PGM_RESUME,
    OP_RESET
  } op_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
  } bus_cycle_s;

  typedef struct packed {
    logic data_polling_bit;
    logic toggle_bit;
    logic time_limit_flag;
    logic erase_timer_flag;
    logic sector_toggle_bit;
    logic buffer_abort_flag;
  } status_s;

endpackage

/* design/flash_bus_cycle.sv */
// One write or read cycle on the flash parallel pins.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module flash_bus_cycle
  import flash_seq_pkg::*;
#(
  parameter int PULSE_CYC = 3
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire bus_cycle_s  cyc_i,
  input  wire logic [15:0] dq_in_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [15:0]      rdata_o,
  output logic [23:0]      addr_o,
  output logic [15:0]      dq_out_o,
  output logic             dq_oe_o,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);

  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  logic [7:0]  cnt;
  logic        wr;
  wire         last = (cnt == 8'(PULSE_CYC));

  // Data pins are asynchronous to clk_i, so they pass two flops first.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= dq_in_i;
      dq_s2 <= dq_s1;
    end
  end

  // Write strobe held low for PULSE_CYC, read strobe for PULSE_CYC+1; reads sample at the end so sync settles.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      cnt      <= 8'h00;
      wr       <= 1'b0;
      addr_o   <= 24'h000000;
      dq_out_o <= 16'h0000;
      rdata_o  <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && start_i) begin
        busy_o   <= 1'b1;
        cnt      <= 8'h00;
        wr       <= write_i;
        addr_o   <= cyc_i.addr;
        dq_out_o <= cyc_i.data;
      end else if (busy_o) begin
        cnt <= cnt + 8'h01;
        if (last) begin
          busy_o  <= 1'b0;
          done_o  <= 1'b1;
          rdata_o <= dq_s2;
        end
      end
    end
  end

  assign dq_oe_o = busy_o && wr;
  assign ce_n_o  = !busy_o;
  assign we_n_o  = !(busy_o && wr && !last);
  assign oe_n_o  = !(busy_o && !wr);

endmodule // flash_bus_cycle

/* design/flash_erase_suspend_sequencer.sv */
// Host controller sequencing flash erase, suspend and resume commands.
// What this block does
// - Sector erase starts only with six writes: unlock, unlock, config, two unlocks, erase.
// - Chip erase starts with six writes ending in the chip erase cycle.
// - Host issues resume and waits for the ready/busy pin, not the toggle bit, before another erase.
// - Resume only when suspended; wait 400us before next erase suspend.
// - Program resume only when suspended; 5us before next program suspend.
// - After a time-limit failure the host must send reset; the block does not enforce it and takes erases once ready returns.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

module flash_erase_suspend_sequencer
  import flash_seq_pkg::*;
#(
  parameter logic [23:0] UNLOCK1_ADDR = `UNLOCK1_ADDR,
  parameter logic [15:0] UNLOCK1_DATA = `UNLOCK1_DATA,
  parameter logic [23:0] UNLOCK2_ADDR = `UNLOCK2_ADDR,
  parameter logic [15:0] UNLOCK2_DATA = `UNLOCK2_DATA,
  parameter logic [15:0] CONFIG_DATA  = `CONFIG_DATA,
  parameter logic [15:0] SECT_DATA    = `SECT_ERASE_DATA,
  parameter logic [15:0] CHIP_DATA    = `CHIP_ERASE_DATA,
  parameter logic [15:0] SUSP_DATA    = `SUSPEND_DATA,
  parameter logic [15:0] RESUME_DATA  = `RESUME_DATA,
  parameter logic [15:0] RESET_DATA   = `RESET_DATA,
  parameter int          ERS_GAP_CYC  = `US_TO_CYC(`ERS_RESUME_US),
  parameter int          PGM_GAP_CYC  = `US_TO_CYC(`PGM_RESUME_US),
  parameter int          SUSP_LAT_CYC = `US_TO_CYC(`SUSPEND_LAT_US)
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        op_valid_i,
  input  wire op_e         op_i,
  input  wire logic [23:0] op_addr_i,
  output logic             op_ready_o,
  output logic             op_done_o,
  output logic             op_refused_o,
  input  wire logic        poll_i,
  input  wire logic [23:0] poll_addr_i,
  output logic             poll_done_o,
  output status_s          status_o,
  output logic             fail_o,
  output logic             toggle_stable_o,
  input  wire logic        ready_busy_n_i,
  output logic             ready_o,
  output logic [23:0]      addr_o,
  output logic [15:0]      dq_out_o,
  output logic             dq_oe_o,
  input  wire logic [15:0] dq_in_i,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);

  typedef enum logic [2:0] {
    S_IDLE, S_WRITE, S_WWAIT, S_READ, S_RWAIT
  } state_e;

  typedef enum logic [1:0] {
    M_READ, M_ERASING, M_ERS_SUSP, M_PGM_SUSP
  } mode_e;

  state_e      state;
  mode_e       mode;
  op_e         cur_op;
  logic [2:0]  step;
  logic [2:0]  nsteps;
  logic [23:0] cur_addr;
  logic [18:0] gap_cnt;
  logic        gap_pgm;
  logic        busy_seen;
  logic        prev_tog;
  logic        have_prev;
  logic        rb_s1;
  logic        rb_s2;
  logic        cyc_done;
  logic [15:0] rdata;
  bus_cycle_s  cyc;

  // Resume to next suspend spacing; the host keeps it, not the device.
  // The counter is shared, so gap_pgm says which suspend it holds back.
  wire gap_open = (gap_cnt == 19'h00000);
  wire ers_ok   = gap_open || gap_pgm;
  wire pgm_ok   = gap_open || !gap_pgm;

  // Commands allowed by the tracked device mode.
  function automatic logic legal(input op_e op, input mode_e m);
    unique case (op)
      OP_SECT_ERASE, OP_CHIP_ERASE:
        legal = (m == M_READ);
      OP_ADD_SECTOR:    legal = (m == M_ERASING);
      OP_ERASE_SUSPEND: legal = (m == M_ERASING) && ers_ok;
      OP_ERASE_RESUME:  legal = (m == M_ERS_SUSP);
      OP_PGM_SUSPEND:   legal = (m == M_READ) && pgm_ok;
      OP_PGM_RESUME:    legal = (m == M_PGM_SUSP);
      OP_RESET:         legal = 1'b1;
    endcase
  endfunction

  // Sequence lengths: full erase setup is six writes, others are single.
  wire [2:0] len_of = (op_i == OP_SECT_ERASE || op_i == OP_CHIP_ERASE)
                      ? 3'(`SETUP_CYCLES) : 3'd1;
  wire accept = (state == S_IDLE) && op_valid_i && legal(op_i, mode);
  wire refuse = (state == S_IDLE) && op_valid_i && !legal(op_i, mode);
  wire start_rd = (state == S_IDLE) && !op_valid_i && poll_i;

  // Address and data of the current write cycle by sequence step.
  wire        is_unl1 = (step == 3'd0) || (step == 3'd3);
  wire        is_unl2 = (step == 3'd1) || (step == 3'd4);
  wire        multi   = (nsteps != 3'd1);
  wire [15:0] final_data =
      (cur_op == OP_CHIP_ERASE)    ? CHIP_DATA :
      (cur_op == OP_ERASE_SUSPEND) ? SUSP_DATA :
      (cur_op == OP_PGM_SUSPEND)   ? SUSP_DATA :
      (cur_op == OP_ERASE_RESUME)  ? RESUME_DATA :
      (cur_op == OP_PGM_RESUME)    ? RESUME_DATA :
      (cur_op == OP_RESET)         ? RESET_DATA : SECT_DATA;
  wire [23:0] final_addr = (cur_op == OP_CHIP_ERASE) ? UNLOCK1_ADDR
                                                     : cur_addr;
  assign cyc.addr = (multi && is_unl1) ? UNLOCK1_ADDR :
                    (multi && is_unl2) ? UNLOCK2_ADDR :
                    (multi && step == 3'd2) ? UNLOCK1_ADDR :
                    (state == S_READ) ? cur_addr : final_addr;
  assign cyc.data = (multi && is_unl1) ? UNLOCK1_DATA :
                    (multi && is_unl2) ? UNLOCK2_DATA :
                    (multi && step == 3'd2) ? CONFIG_DATA : final_data;

  // Sequence and poll state machine.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state    <= S_IDLE;
      cur_op   <= OP_RESET;
      step     <= 3'd0;
      nsteps   <= 3'd1;
      cur_addr <= 24'h000000;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (accept) begin
            state    <= S_WRITE;
            cur_op   <= op_i;
            cur_addr <= op_addr_i;
            nsteps   <= len_of;
            step     <= 3'd0;
          end else if (start_rd) begin
            state    <= S_READ;
            cur_addr <= poll_addr_i;
          end
        end
        S_WRITE: state <= S_WWAIT;
        S_WWAIT: begin
          if (cyc_done) begin
            if (step == nsteps - 3'd1) begin
              state <= S_IDLE;
            end else begin
              step  <= step + 3'd1;
              state <= S_WRITE;
            end
          end
        end
        S_READ:  state <= S_RWAIT;
        S_RWAIT: if (cyc_done) state <= S_IDLE;
      endcase
    end
  end

  wire seq_end = (state == S_WWAIT) && cyc_done && (step == nsteps - 3'd1);

  // Mode tracking, which lets the controller refuse illegal orders early.
  // The busy pin arrives two flops late, so ready only ends an erase once
  // a busy level has been seen after the last write of the sequence.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode    <= M_READ;
      gap_cnt <= 19'h00000;
      gap_pgm <= 1'b0;
      busy_seen <= 1'b0;
    end else begin
      if (!gap_open) gap_cnt <= gap_cnt - 19'h00001;
      if (seq_end) begin
        busy_seen <= 1'b0;
        unique case (cur_op)
          OP_SECT_ERASE, OP_CHIP_ERASE, OP_ADD_SECTOR:
            mode <= M_ERASING;
          OP_ERASE_SUSPEND: mode <= M_ERS_SUSP;
          OP_PGM_SUSPEND:   mode <= M_PGM_SUSP;
          OP_ERASE_RESUME: begin
            mode    <= M_ERASING;
            gap_cnt <= 19'(ERS_GAP_CYC);
            gap_pgm <= 1'b0;
          end
          OP_PGM_RESUME: begin
            mode    <= M_READ;
            gap_cnt <= 19'(PGM_GAP_CYC);
            gap_pgm <= 1'b1;
          end
          OP_RESET: mode <= M_READ;
        endcase
      end else if (mode == M_ERASING && !rb_s2) begin
        busy_seen <= 1'b1;
      end else if (mode == M_ERASING && state == S_IDLE && busy_seen) begin
        mode <= M_READ;     // Ready again: erase ended or aborted.
      end
    end
  end

  // Ready/busy pin is asynchronous; two flops before use.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      rb_s1 <= ready_busy_n_i;
      rb_s2 <= rb_s1;
    end
  end

  // Status capture; toggle stable means two equal successive toggle bits.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_o        <= '0;
      fail_o          <= 1'b0;
      toggle_stable_o <= 1'b0;
      prev_tog        <= 1'b0;
      have_prev       <= 1'b0;
      poll_done_o     <= 1'b0;
      op_done_o       <= 1'b0;
      op_refused_o    <= 1'b0;
    end else begin
      poll_done_o  <= 1'b0;
      op_done_o    <= seq_end;
      op_refused_o <= refuse;
      if (seq_end) have_prev <= 1'b0;
      if (state == S_RWAIT && cyc_done) begin
        poll_done_o <= 1'b1;
        status_o.data_polling_bit  <= rdata[`ST_POLL];
        status_o.toggle_bit        <= rdata[`ST_TOGGLE];
        status_o.time_limit_flag   <= rdata[`ST_TLIMIT];
        status_o.erase_timer_flag  <= rdata[`ST_ETIMER];
        status_o.sector_toggle_bit <= rdata[`ST_STOGGLE];
        status_o.buffer_abort_flag <= rdata[`ST_BABORT];
        fail_o          <= rdata[`ST_TLIMIT] && !rb_s2;
        prev_tog        <= rdata[`ST_TOGGLE];
        have_prev       <= 1'b1;
        toggle_stable_o <= have_prev &&
                           (prev_tog == rdata[`ST_TOGGLE]);
      end
    end
  end

  assign op_ready_o = (state == S_IDLE);
  assign ready_o    = rb_s2;

  flash_bus_cycle u_cycle (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .start_i  ((state == S_WRITE) || (state == S_READ)),
    .write_i  (state == S_WRITE),
    .cyc_i    (cyc),
    .dq_in_i  (dq_in_i),
    .busy_o   (),
    .done_o   (cyc_done),
    .rdata_o  (rdata),
    .addr_o   (addr_o),
    .dq_out_o (dq_out_o),
    .dq_oe_o  (dq_oe_o),
    .ce_n_o   (ce_n_o),
    .we_n_o   (we_n_o),
    .oe_n_o   (oe_n_o)
  );

endmodule // flash_erase_suspend_sequencer

/* testbench/flash_seq_props.sv */
// Checker on the ports of the flash erase sequencer host controller.
`timescale 1ns/1ps

module flash_seq_props
  import flash_seq_pkg::*;
(
  input wire logic    clk_i,
  input wire logic    rstn_i,
  input wire logic    op_valid_i,
  input wire logic    op_ready_o,
  input wire logic    op_done_o,
  input wire logic    op_refused_o,
  input wire logic    poll_done_o,
  input wire status_s status_o,
  input wire logic    ready_busy_n_i,
  input wire logic    ready_o,
  input wire logic    dq_oe_o,
  input wire logic    ce_n_o,
  input wire logic    we_n_o,
  input wire logic    oe_n_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Reads and writes never overlap on the shared data pins; a write strobe stays low three cycles.
  write_strobe_a: assert property (
    !we_n_o |-> !ce_n_o && oe_n_o && dq_oe_o) else $error("write strobe");
  read_strobe_a: assert property (
    !oe_n_o |-> !ce_n_o && we_n_o && !dq_oe_o) else $error("read strobe");
  we_pulse_a: assert property (
    $fell(we_n_o) |=> !we_n_o ##1 !we_n_o ##1 we_n_o) else $error("we width");
  // Every taken order ends in a completion or a refusal; a completion is one pulse.
  answer_bound_a: assert property (
    op_ready_o && op_valid_i |-> ##[1:60] (op_done_o || op_refused_o))
    else $error("order unanswered");
  done_pulse_a: assert property (
    op_done_o |=> !op_done_o) else $error("done too long");
  refuse_excl_a: assert property (
    op_refused_o |-> !op_done_o && !poll_done_o) else $error("refused+done");
  // Status holds between polls; the busy pin passes two flops.
  status_hold_a: assert property (
    !poll_done_o |-> $stable(status_o)) else $error("status moved");
  ready_sync_a: assert property (
    ready_o == $past(ready_busy_n_i, 2)) else $error("ready not synced");
endmodule // flash_seq_props

bind flash_erase_suspend_sequencer flash_seq_props props (
  .clk_i, .rstn_i, .op_valid_i, .op_ready_o, .op_done_o, .op_refused_o,
  .poll_done_o, .status_o, .ready_busy_n_i, .ready_o, .dq_oe_o, .ce_n_o,
  .we_n_o, .oe_n_o);

/* testbench/flash_dev_model.sv */
// Behavioural flash device that answers the sequencer's bus cycles.
`timescale 1ns/1ps
`include "flash_seq_regs.svh"

// Window and erase counts are short so the run stays brief.
module flash_dev_model #(
  parameter int WIN = 200,
  parameter int ERS = 400,
  parameter int SL  = 20
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  output logic [15:0]      dq_o,
  output logic             ready_busy_n_o
);
  typedef enum logic [1:0] {M_READ, M_WIN, M_ERASE, M_SUSP} mode_e;
  mode_e       mode;
  int          step, tmr, sus;
  logic        we_q, oe_q, tog, stog;
  logic [15:0] last, wd;
  logic [7:0]  st;
  wire         wr = we_n_i && !we_q;
  wire         rd_end = oe_n_i && !oe_q;

  // Abort and time-limit flags stay 0: no failure is modelled.
  // A released bus shows the inverse of its last value, never a copy.
  assign st = {mode == M_SUSP, tog, 2'h0, mode != M_WIN, stog, 2'h0};
  assign ready_busy_n_o = !(mode == M_WIN || mode == M_ERASE);
  assign dq_o = (oe_n_i || ce_n_i) ? ~last
              : (mode == M_READ) ? 16'hFFFF : {8'h00, st};

  // Decode finished writes and run the window, erase and suspend timers.
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= M_READ;
      {step, tmr, sus} <= '0;
      {we_q, oe_q, tog, stog, last, wd} <= '1;
    end else begin
      we_q <= we_n_i;
      oe_q <= oe_n_i;
      if (!we_n_i && !ce_n_i) wd <= dq_i;
      if (!oe_n_i && !ce_n_i) last <= dq_o;
      if (rd_end && mode inside {M_WIN, M_ERASE}) tog <= !tog;
      // Every poll of the bench addresses a sector selected for erase.
      if (rd_end && mode != M_READ) stog <= !stog;
      case (mode)
        M_READ: if (wr) begin
          step <= (step == 5 || wd == `RESET_DATA) ? 0 : step + 1;
          tmr <= (wd == `CHIP_ERASE_DATA) ? 0 : WIN;
          if (step == 5 && wd == `SECT_ERASE_DATA) mode <= M_WIN;
          if (step == 5 && wd == `CHIP_ERASE_DATA) mode <= M_ERASE;
        end
        M_WIN: if (wr && wd == `SECT_ERASE_DATA) tmr <= WIN;
          else if (wr && wd == `SUSPEND_DATA) mode <= M_SUSP;
          else if (wr) mode <= M_READ;
          else if (tmr > 0) tmr <= tmr - 1;
          else mode <= M_ERASE;
        M_ERASE: if (sus == 1) mode <= M_SUSP;
          else if (sus > 1) sus <= sus - 1;
          else if (wr && wd == `SUSPEND_DATA) sus <= SL;
          else if (tmr < ERS) tmr <= tmr + 1;
          else mode <= M_READ;
        M_SUSP: if (wr && wd == `RESUME_DATA) begin
          mode <= M_ERASE;
          sus <= 0;
        end
        default: mode <= M_READ;
      endcase
    end
  end
endmodule // flash_dev_model

/* testbench/flash_erase_suspend_sequencer_tb.sv */
// Self-checking bench for the flash erase sequencer host controller.
`timescale 1ns/1ps

module flash_erase_suspend_sequencer_tb
  import flash_seq_pkg::*;
;
  typedef struct packed {
    op_e         op;
    logic [23:0] addr;
    logic        refused;
  } row_s;
  logic        clk_i, rstn_i, op_valid_i, poll_i, ready_busy_n_i, rf;
  logic        op_ready_o, op_done_o, op_refused_o, poll_done_o, fail_o;
  logic        toggle_stable_o, ready_o, dq_oe_o, ce_n_o, we_n_o, oe_n_o;
  op_e         op_i;
  status_s     status_o;
  logic [23:0] op_addr_i, poll_addr_i, addr_o;
  logic [15:0] dq_out_o, dq_in_i, dev_dq;
  int          mismatches, checks, n;
  // Orders around the window; refusals follow the tracked mode.
  row_s        rows [8] = '{
    '{OP_SECT_ERASE, 24'h010000, 1'h0}, '{OP_ADD_SECTOR, 24'h020000, 1'h0},
    '{OP_CHIP_ERASE, 24'h000000, 1'h1}, '{OP_ERASE_RESUME, 24'h000000, 1'h1},
    '{OP_PGM_RESUME, 24'h000000, 1'h1}, '{OP_ERASE_SUSPEND, 24'h000000, 1'h0},
    '{OP_SECT_ERASE, 24'h030000, 1'h1}, '{OP_ERASE_RESUME, 24'h000000, 1'h0}};

  flash_erase_suspend_sequencer #(
    .ERS_GAP_CYC(8),
    .PGM_GAP_CYC(8)
  ) dut (
    .clk_i, .rstn_i, .op_valid_i, .op_i, .op_addr_i, .op_ready_o, .op_done_o,
    .op_refused_o, .poll_i, .poll_addr_i, .poll_done_o, .status_o, .fail_o,
    .toggle_stable_o, .ready_busy_n_i, .ready_o, .addr_o, .dq_out_o,
    .dq_oe_o, .dq_in_i, .ce_n_o, .we_n_o, .oe_n_o);
  // The controller drives the data pins during writes, the device otherwise.
  assign dq_in_i = dq_oe_o ? dq_out_o : dev_dq;
  flash_dev_model dev (
    .clk_i, .rstn_i, .dq_i(dq_out_o), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .dq_o(dev_dq), .ready_busy_n_o(ready_busy_n_i));

  // Free-running 40 MHz clock.
  always #12.5 clk_i = ~clk_i;

  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Requests rise just after an edge and hold until the take edge.
  task automatic do_op(input op_e op, input logic [23:0] a);
    int k;
    while (op_ready_o !== 1'h1) tick();
    op_valid_i = 1'h1;
    op_i = op;
    op_addr_i = a;
    tick();
    op_valid_i = 1'h0;
    for (k = 0; k < 80 && (op_done_o | op_refused_o) !== 1'h1; k++) tick();
    chk("op_answer", 1'h1, op_done_o | op_refused_o);
    rf = op_refused_o;
    tick();
  endtask
  task automatic do_poll();
    int k;
    while (op_ready_o !== 1'h1) tick();
    poll_i = 1'h1;
    tick();
    poll_i = 1'h0;
    for (k = 0; k < 60 && poll_done_o !== 1'h1; k++) tick();
    chk("poll_done", 1'h1, poll_done_o);
  endtask

  // Main sequence: table rows first, then the timed cases by hand.
  initial begin
    {clk_i, rstn_i, op_valid_i, poll_i} = 4'h0;
    op_i = OP_RESET;
    op_addr_i = 24'h000000;
    poll_addr_i = 24'h010000;
    {mismatches, checks} = '0;
    repeat (20) tick();
    rstn_i = 1'h1;
    for (int i = 0; i < 8; i++) begin
      do_op(rows[i].op, rows[i].addr);
      chk("refused", rows[i].refused, rf);
    end
    do_poll();
    do_poll();
    chk("erase_timer", 1'h1, status_o.erase_timer_flag);
    chk("polling", 1'h0, status_o.data_polling_bit);
    chk("toggle_stable", 1'h0, toggle_stable_o);
    chk("ready", 1'h0, ready_o);
    chk("time_limit", 1'h0, status_o.time_limit_flag);
    chk("buffer_abort", 1'h0, status_o.buffer_abort_flag);
    chk("fail", 1'h0, fail_o);
    // A suspend in mid-erase shows only after the device latency.
    do_op(OP_ERASE_SUSPEND, 24'h000000);
    chk("refused", 1'h0, rf);
    do_poll();
    chk("polling", 1'h0, status_o.data_polling_bit);
    for (n = 0; n < 20 && status_o.data_polling_bit !== 1'h1; n++) do_poll();
    do_poll();
    chk("polling", 1'h1, status_o.data_polling_bit);
    chk("toggle_stable", 1'h1, toggle_stable_o);
    chk("ready", 1'h1, ready_o);
    do_op(OP_ERASE_RESUME, 24'h000000);
    chk("refused", 1'h0, rf);
    repeat (4) tick();
    for (n = 0; n < 1000 && ready_o !== 1'h1; n++) tick();
    chk("ready", 1'h1, ready_o);
    // Chip erase from read mode, cut short by a hardware reset.
    repeat (4) tick();
    do_op(OP_CHIP_ERASE, 24'h000000);
    chk("refused", 1'h0, rf);
    repeat (4) tick();
    chk("ready", 1'h0, ready_o);
    rstn_i = 1'h0;
    #1;
    chk("we_n", 1'h1, we_n_o);
    chk("op_ready", 1'h1, op_ready_o);
    repeat (20) tick();
    rstn_i = 1'h1;
    repeat (4) tick();
    chk("ready", 1'h1, ready_o);
    do_op(OP_RESET, 24'h000000);
    chk("refused", 1'h0, rf);
    do_op(OP_PGM_SUSPEND, 24'h000000);
    chk("refused", 1'h0, rf);
    chk("ready", 1'h1, ready_o);
    complete_run();
  end

  // Watchdog well beyond the several hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
endmodule // flash_erase_suspend_sequencer_tb
